// File: logic/alu_ops_defs.svh
// Offsets, field positions, opcodes and reset values of the ALU block
`ifndef ALU_OPS_DEFS_SVH
`define ALU_OPS_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define ADDR_INSTR      8'h00
`define ADDR_ACC        8'h04
`define ADDR_STATUS     8'h08
`define ADDR_FILE_ADDR  8'h0C
`define ADDR_FILE_DATA  8'h10
`define ADDR_PORT       8'h14
`define ADDR_PORT_DIR   8'h18

// Status register bit positions
`define ST_CARRY        0
`define ST_HALF_CARRY   1
`define ST_ZERO         2
`define ST_BUSY         8

// Opcode fields of the instruction word
`define OPC_ADD_IMM     5'h1F
`define OPC_AND_IMM     6'h39
`define OPC_ADD_REG     6'h07
`define OPC_AND_REG     6'h05
`define INSTR_W         14
`define DEST_BIT        7

// File register space
`define FILE_DEPTH      128
`define FILE_AW         7
`define PORT_FADDR      7'h06

// Reset values
`define RST_ACC         8'h00
`define RST_LATCH       8'h00
`define RST_DIR         8'h00

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define RESP_DECERR     2'h3

`endif

// File: logic/alu_ops_pkg.sv
// Types shared by the ALU block and its test bench
package alu_ops_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD_IMM,
    OP_AND_IMM,
    OP_ADD_REG,
    OP_AND_REG
  } op_e;

  typedef enum logic [2:0] {
    S_IDLE,
    S_Q1,
    S_Q2,
    S_Q3,
    S_Q4
  } phase_e;

  typedef struct packed {
    op_e        kind;
    logic       dest_file;
    logic [6:0] faddr;
    logic [7:0] k;
  } instr_s;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } flags_s;

  typedef struct packed {
    logic [7:0] res;
    flags_s     fl;
  } alu_out_s;

endpackage

// File: logic/file_ram.sv
// File register memory with registered read data
`timescale 1ns/1ps
`include "alu_ops_defs.svh"

module file_ram (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   we,
  input  wire logic [`FILE_AW-1:0]    waddr,
  input  wire logic [7:0]             wdata,
  input  wire logic [`FILE_AW-1:0]    raddr,
  output logic      [7:0]             rdata
);

  logic [7:0] mem [`FILE_DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule // file_ram

// File: logic/alu_ops.sv
// Accumulator add and AND instructions behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "alu_ops_defs.svh"

// Notes on behaviour
// - Add-immediate (upper field 111x) adds the literal to the accumulator, updating carry, half carry and zero.
// - And-immediate (field 1001) ANDs the literal into the accumulator and changes only zero.
// - Add-register (field 0111) sums accumulator and file register, updating carry, half carry and zero.
// - And-register (field 0101) ANDs accumulator and file register, changing only zero.
// - For register ops a destination bit of 0 writes the accumulator and 1 writes the file register.
// - One instruction cycle is four clock periods.
// - A register op whose source is the port register uses the synchronised pin levels, not the latch.
module alu_ops
  import alu_ops_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [7:0]    araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  input  wire logic [7:0]    port_pins_in,
  output logic [7:0]         port_pins_out,
  output logic [7:0]         port_pins_oe
);
  import alu_ops_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  function automatic instr_s decode(input logic [`INSTR_W-1:0] w);
    instr_s d;
    d.kind      = OP_NONE;
    d.faddr     = w[6:0];
    d.k         = w[7:0];
    if (w[13:9] == `OPC_ADD_IMM) begin
      d.kind = OP_ADD_IMM;
    end else if (w[13:8] == `OPC_AND_IMM) begin
      d.kind = OP_AND_IMM;
    end else if (w[13:8] == `OPC_ADD_REG) begin
      d.kind = OP_ADD_REG;
    end else if (w[13:8] == `OPC_AND_REG) begin
      d.kind = OP_AND_REG;
    end
    d.dest_file = w[`DEST_BIT] &
                  ((d.kind == OP_ADD_REG) || (d.kind == OP_AND_REG));
    return d;
  endfunction

  function automatic alu_out_s alu(input op_e kind, input logic [7:0] w,
                                   input logic [7:0] f, input flags_s fl);
    logic [8:0] sum;
    logic [4:0] low;
    alu_out_s   o;
    sum  = {1'b0, w} + {1'b0, f};
    low  = {1'b0, w[3:0]} + {1'b0, f[3:0]};
    o.fl = fl;
    if (kind == OP_ADD_IMM || kind == OP_ADD_REG) begin
      o.res   = sum[7:0];
      o.fl.c  = sum[8];
      o.fl.dc = low[4];
    end else begin
      o.res   = w & f;
    end
    o.fl.z = (o.res == 8'h00);
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  phase_e                 state_q,   state_d;
  instr_s                 ins_q,     ins_d;
  logic [`INSTR_W-1:0]    iword_q,   iword_d;
  logic [7:0]             acc_q,     acc_d;
  flags_s                 flags_q,   flags_d;
  logic [7:0]             op_q,      op_d;
  logic [`FILE_AW-1:0]    faddr_q,   faddr_d;
  logic [7:0]             latch_q,   latch_d;
  logic [7:0]             dir_q,     dir_d;
  logic [7:0]             pins_m_q;
  logic [7:0]             pins_s_q;
  logic                   bvalid_q,  bvalid_d;
  logic [1:0]             bresp_q,   bresp_d;
  logic                   rd1_q,     rd1_d;
  logic                   rd2_q,     rd2_d;
  logic                   rconf_q,   rconf_d;
  logic [7:0]             rd_addr_q, rd_addr_d;
  logic                   rvalid_q,  rvalid_d;
  logic [31:0]            rdata_q,   rdata_d;
  logic [1:0]             rresp_q,   rresp_d;
  logic                   busy;
  logic                   wr_go;
  logic                   ar_go;
  logic                   start_go;
  logic                   ram_we;
  logic [`FILE_AW-1:0]    ram_waddr;
  logic [7:0]             ram_wdata;
  logic [`FILE_AW-1:0]    ram_raddr;
  logic [7:0]             ram_rdata;
  alu_out_s               alu_o;
  instr_s                 dec;
  logic                   is_reg;

  assign busy     = (state_q != S_IDLE);
  assign wr_go    = awvalid && wvalid && !bvalid_q;
  assign ar_go    = arvalid && !rd1_q && !rd2_q && !rvalid_q;
  assign awready  = wr_go;
  assign wready   = wr_go;
  assign arready  = ar_go;
  assign is_reg   = (ins_q.kind == OP_ADD_REG) || (ins_q.kind == OP_AND_REG);
  assign dec      = decode(wdata[`INSTR_W-1:0]);
  assign start_go = wr_go && (awaddr == `ADDR_INSTR) && !busy &&
                    (wstrb[1:0] == 2'h3) && (dec.kind != OP_NONE);
  assign alu_o    = alu(ins_q.kind, acc_q, op_q, flags_q);

  file_ram u_file_ram (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr   (ram_raddr),
    .rdata   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d   = state_q;
    ins_d     = ins_q;
    iword_d   = iword_q;
    acc_d     = acc_q;
    flags_d   = flags_q;
    op_d      = op_q;
    faddr_d   = faddr_q;
    latch_d   = latch_q;
    dir_d     = dir_q;
    bvalid_d  = bvalid_q && !bready;
    bresp_d   = bresp_q;
    ram_we    = 1'b0;
    ram_waddr = faddr_q;
    ram_wdata = wdata[7:0];
    ram_raddr = busy ? ins_q.faddr : faddr_q;

    // Instruction cycle: Q1 read, Q2 capture operand, Q4 commit
    unique case (state_q)
      S_IDLE: ;
      S_Q1: state_d = S_Q2;
      S_Q2: begin
        state_d = S_Q3;
        if (!is_reg) begin
          op_d = ins_q.k;
        end else if (ins_q.faddr == `PORT_FADDR) begin
          op_d = pins_s_q;
        end else begin
          op_d = ram_rdata;
        end
      end
      S_Q3: state_d = S_Q4;
      S_Q4: begin
        state_d = S_IDLE;
        flags_d = alu_o.fl;
        if (ins_q.dest_file) begin
          if (ins_q.faddr == `PORT_FADDR) begin
            latch_d = alu_o.res;
          end else begin
            ram_we    = 1'b1;
            ram_waddr = ins_q.faddr;
            ram_wdata = alu_o.res;
          end
        end else begin
          acc_d = alu_o.res;
        end
      end
    endcase

    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = `RESP_OKAY;
      unique case (awaddr)
        `ADDR_INSTR: begin
          if (busy || dec.kind == OP_NONE) begin
            bresp_d = `RESP_SLVERR;
          end else if (start_go) begin
            ins_d   = dec;
            iword_d = wdata[`INSTR_W-1:0];
            state_d = S_Q1;
          end
        end
        `ADDR_ACC: begin
          if (busy) begin
            bresp_d = `RESP_SLVERR;
          end else if (wstrb[0]) begin
            acc_d = wdata[7:0];
          end
        end
        `ADDR_STATUS: begin
          if (busy) begin
            bresp_d = `RESP_SLVERR;
          end else if (wstrb[0]) begin
            flags_d.c  = wdata[`ST_CARRY];
            flags_d.dc = wdata[`ST_HALF_CARRY];
            flags_d.z  = wdata[`ST_ZERO];
          end
        end
        `ADDR_FILE_ADDR: begin
          if (wstrb[0]) begin
            faddr_d = wdata[`FILE_AW-1:0];
          end
        end
        `ADDR_FILE_DATA: begin
          if (busy) begin
            bresp_d = `RESP_SLVERR;
          end else if (wstrb[0]) begin
            ram_we = 1'b1;
          end
        end
        `ADDR_PORT: begin
          if (busy) begin
            bresp_d = `RESP_SLVERR;
          end else if (wstrb[0]) begin
            latch_d = wdata[7:0];
          end
        end
        `ADDR_PORT_DIR: begin
          if (wstrb[0]) begin
            dir_d = wdata[7:0];
          end
        end
        default: bresp_d = `RESP_DECERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd1_d     = 1'b0;
    rd2_d     = rd1_q;
    rconf_d   = rconf_q;
    rd_addr_d = rd_addr_q;
    rvalid_d  = rvalid_q && !rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (ar_go) begin
      rd1_d     = 1'b1;
      rd_addr_d = araddr;
    end
    if (rd1_q) begin
      rconf_d = busy;
    end
    if (rd2_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      unique case (rd_addr_q)
        `ADDR_INSTR:     rdata_d[`INSTR_W-1:0] = iword_q;
        `ADDR_ACC:       rdata_d[7:0] = acc_q;
        `ADDR_STATUS: begin
          rdata_d[`ST_CARRY]      = flags_q.c;
          rdata_d[`ST_HALF_CARRY] = flags_q.dc;
          rdata_d[`ST_ZERO]       = flags_q.z;
          rdata_d[`ST_BUSY]       = busy;
        end
        `ADDR_FILE_ADDR: rdata_d[`FILE_AW-1:0] = faddr_q;
        `ADDR_FILE_DATA: begin
          if (rconf_q) begin
            rresp_d = `RESP_SLVERR;
          end else begin
            rdata_d[7:0] = ram_rdata;
          end
        end
        `ADDR_PORT:      rdata_d[7:0] = pins_s_q;
        `ADDR_PORT_DIR:  rdata_d[7:0] = dir_q;
        default:         rresp_d = `RESP_DECERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= S_IDLE;
      ins_q     <= '0;
      iword_q   <= '0;
      acc_q     <= `RST_ACC;
      flags_q   <= '0;
      op_q      <= 8'h00;
      faddr_q   <= '0;
      latch_q   <= `RST_LATCH;
      dir_q     <= `RST_DIR;
      pins_m_q  <= 8'h00;
      pins_s_q  <= 8'h00;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      rd1_q     <= 1'b0;
      rd2_q     <= 1'b0;
      rconf_q   <= 1'b0;
      rd_addr_q <= 8'h00;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `RESP_OKAY;
    end else begin
      state_q   <= state_d;
      ins_q     <= ins_d;
      iword_q   <= iword_d;
      acc_q     <= acc_d;
      flags_q   <= flags_d;
      op_q      <= op_d;
      faddr_q   <= faddr_d;
      latch_q   <= latch_d;
      dir_q     <= dir_d;
      pins_m_q  <= port_pins_in;
      pins_s_q  <= pins_m_q;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rd1_q     <= rd1_d;
      rd2_q     <= rd2_d;
      rconf_q   <= rconf_d;
      rd_addr_q <= rd_addr_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign rvalid        = rvalid_q;
  assign rdata         = rdata_q;
  assign rresp         = rresp_q;
  assign port_pins_out = latch_q;
  assign port_pins_oe  = dir_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic commit;
  assign commit = (state_q == S_Q4);

  sequence s_start;
    start_go;
  endsequence

  sequence s_four_phases;
    busy [*4] ##1 !busy;
  endsequence

  a_add_imm_sum: assert property (
    commit && ins_q.kind == OP_ADD_IMM |=>
      acc_q == 8'($past(acc_q) + $past(op_q)))
    else $error("add immediate sum wrong");

  a_and_imm_flags: assert property (
    commit && ins_q.kind == OP_AND_IMM |=>
      acc_q == ($past(acc_q) & $past(op_q)) &&
      $stable(flags_q.c) && $stable(flags_q.dc))
    else $error("and immediate result or flags wrong");

  a_add_reg_carry: assert property (
    commit && ins_q.kind == OP_ADD_REG |=>
      flags_q.c == 1'(({1'b0, $past(acc_q)} + {1'b0, $past(op_q)}) >> 8)
      && flags_q.dc == 1'(({1'b0, $past(acc_q[3:0])} +
                           {1'b0, $past(op_q[3:0])}) >> 4))
    else $error("add register carry wrong");

  a_and_reg_zero: assert property (
    commit && ins_q.kind == OP_AND_REG |=>
      flags_q.z == (($past(acc_q) & $past(op_q)) == 8'h00) &&
      $stable(flags_q.c))
    else $error("and register zero flag wrong");

  a_dest_file_acc: assert property (
    commit && is_reg && ins_q.dest_file |=> $stable(acc_q))
    else $error("file destination changed accumulator");

  a_dest_file_write: assert property (
    commit && is_reg && ins_q.dest_file &&
    ins_q.faddr != `PORT_FADDR |->
      ram_we && ram_waddr == ins_q.faddr && ram_wdata == alu_o.res)
    else $error("file destination not written");

  a_single_cycle: assert property (
    s_start |=> s_four_phases)
    else $error("instruction cycle not four clocks");

  a_port_operand: assert property (
    state_q == S_Q2 && is_reg && ins_q.faddr == `PORT_FADDR |=>
      op_q == $past(pins_s_q))
    else $error("port operand not taken from pins");

  a_busy_refuse: assert property (
    wr_go && busy && awaddr == `ADDR_ACC |=>
      bresp == `RESP_SLVERR && acc_q == $past(acc_d))
    else $error("write while busy not refused");

endmodule // alu_ops

// File: tb/test_add_and_accumulator_ops.sv
// Self-checking bench for the accumulator add and AND block
`timescale 1ns/1ps
`include "alu_ops_defs.svh"

module test_add_and_accumulator_ops;
  import alu_ops_pkg::*;

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic [7:0]  port_pins_in = 8'h00;
  logic [7:0]  port_pins_out;
  logic [7:0]  port_pins_oe;
  logic [7:0]  pp = 8'h00;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cyc = 0;
  int          t0, t1;
  int          seed = 77;
  int          acc_m, c_m, dc_m, z_m, pins_m, port_m;
  int          file_m [128];

  alu_ops dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
    .port_pins_oe(port_pins_oe)
  );

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and commit timing probe
  task automatic results();
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      miscompares++;
      results();
    end
  end

  // Instruction accept and port latch change, seen between edges
  always @(negedge aclk) begin
    if (awvalid && awready && awaddr == `ADDR_INSTR) t0 = cyc;
    if (port_pins_out !== pp) begin
      t1 = cyc;
      pp = port_pins_out;
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t response %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master tasks, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    do rd(`ADDR_STATUS, d, r); while (d[`ST_BUSY] !== 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reference model of one instruction, then execution and readback
  task automatic exec(input int op, input int d, input int f, input int k,
                      input bit poke);
    int          opnd, res;
    logic [13:0] w;
    logic [31:0] v;
    logic [1:0]  r;
    case (op)
      0:       w = {`OPC_ADD_IMM, 1'(d), 8'(k)};
      1:       w = {`OPC_AND_IMM, 8'(k)};
      2:       w = {`OPC_ADD_REG, 1'(d), 7'(f)};
      default: w = {`OPC_AND_REG, 1'(d), 7'(f)};
    endcase
    opnd = (op < 2) ? k : (f == 6) ? pins_m : file_m[f];
    res  = (op % 2 == 0) ? acc_m + opnd : acc_m & opnd;
    if (op % 2 == 0) begin
      c_m  = res >> 8;
      dc_m = ((acc_m & 15) + (opnd & 15)) >> 4;
    end
    res = res & 255;
    z_m = (res == 0);
    if (op < 2 || d == 0) acc_m = res;
    else if (f == 6) port_m = res;
    else file_m[f] = res;
    wr(`ADDR_INSTR, 32'(w), r);
    check_resp(r, `RESP_OKAY);
    if (poke) begin
      // Accumulator write during execution must bounce
      wr(`ADDR_ACC, 32'h0000_00EE, r);
      check_resp(r, `RESP_SLVERR);
    end
    wait_idle();
    rd(`ADDR_ACC, v, r);
    check_word(v, 32'(acc_m));
    rd(`ADDR_STATUS, v, r);
    check_word(v, 32'(z_m * 4 + dc_m * 2 + c_m));
    if (f != 6) begin
      rd(`ADDR_FILE_DATA, v, r);
      check_word(v, 32'(file_m[f]));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    int          a, fl, f, k;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ADDR_ACC, v, r);
    check_word(v, 32'h0);
    rd(`ADDR_STATUS, v, r);
    check_word(v, 32'h0);
    check_word({16'h0, port_pins_out, port_pins_oe}, 32'h0);
    wr(`ADDR_PORT_DIR, 32'h0000_00A5, r);
    check_word({24'h0, port_pins_oe}, 32'h0000_00A5);
    // Unmapped place and undefined opcode
    wr(8'h1C, 32'h1, r);
    check_resp(r, `RESP_DECERR);
    rd(8'h1C, v, r);
    check_resp(r, `RESP_DECERR);
    check_word(v, 32'h0);
    wr(`ADDR_INSTR, 32'h0, r);
    check_resp(r, `RESP_SLVERR);
    for (int i = 0; i < 48; i++) begin
      a  = (i == 0) ? 255 : $random(seed) & 255;
      k  = (i == 0) ? 1 : $random(seed) & 255;
      fl = $random(seed) & 7;
      f  = $random(seed) & 127;
      if (f == 6) f = 7;
      wr(`ADDR_ACC, 32'(a), r);
      acc_m = a;
      wr(`ADDR_STATUS, 32'(fl), r);
      c_m  = fl & 1;
      dc_m = (fl >> 1) & 1;
      z_m  = fl >> 2;
      wr(`ADDR_FILE_ADDR, 32'(f), r);
      file_m[f] = $random(seed) & 255;
      wr(`ADDR_FILE_DATA, 32'(file_m[f]), r);
      exec(i % 4, $random(seed) & 1, f, k, i == 1);
    end
    // Port source reads the pins, result lands in the latch
    pins_m = 8'h30;
    port_pins_in <= 8'h30;
    wr(`ADDR_PORT, 32'h0000_000F, r);
    rd(`ADDR_PORT, v, r);
    check_word(v, 32'h0000_0030);
    wr(`ADDR_ACC, 32'h0000_0005, r);
    acc_m = 5;
    exec(2, 1, 6, 0, 1'b0);
    check_word({24'h0, port_pins_out}, 32'(port_m));
    // Accept edge plus four clocks to commit
    check_word(32'(t1 - t0), 32'h5);
    results();
  end
endmodule // test_add_and_accumulator_ops
